// ==== rtl/kpsc_pkg.sv ====
// Constants and types shared by the keypad scan and input event block.
// Assumes a 25 MHz system clock and a 16-bit register port.
`default_nettype none
package kpsc_pkg;
	localparam int CLK_MHZ = 25;
	localparam int DEBOUNCE_US = 50;
	localparam logic [10:0] DEBOUNCE_CYC = 11'(DEBOUNCE_US * CLK_MHZ);

	localparam int NUM_ROWS = 5;
	localparam int NUM_COLS = 5;
	localparam int NUM_PINS = 10;
	localparam int NUM_KEYS = 30;
	localparam int FIFO_DEPTH = 16;

	localparam logic [3:0] REG_KEY_PINS = 4'h0;
	localparam logic [3:0] REG_SCAN_WAIT = 4'h1;
	localparam logic [3:0] REG_STATUS = 4'h2;
	localparam logic [3:0] REG_CTRL = 4'h3;
	localparam logic [3:0] REG_EVENT_COUNT = 4'h4;
	localparam logic [3:0] REG_FIFO_POP = 4'h5;
	localparam logic [3:0] REG_INPUT_LEVEL = 4'h6;
	localparam logic [3:0] REG_INPUT_IRQ_EN = 4'h7;
	localparam logic [3:0] REG_INPUT_IRQ_STATUS = 4'h8;
	localparam logic [3:0] REG_INPUT_POLARITY = 4'h9;
	localparam logic [3:0] REG_INPUT_EVENT_EN = 4'hA;
	localparam logic [3:0] REG_OUTPUT_EN = 4'hB;
	localparam logic [3:0] REG_OUTPUT_DATA = 4'hC;

	localparam int STATUS_EVENT_BIT = 0;
	localparam int STATUS_INPUT_BIT = 1;
	localparam int STATUS_OVF_BIT = 2;
	localparam int CTRL_OVF_IRQ_EN_BIT = 0;
	localparam int ENTRY_FLAG_BIT = 7;

	localparam logic [15:0] SCAN_WAIT_RESET = 16'h0FA0;
	localparam logic [6:0] EXT_KEY_BASE = 7'h1F;
	localparam logic [6:0] INPUT_ID_BASE = 7'h25;
	localparam logic [4:0] FIFO_FULL = 5'h10;

	typedef enum logic [4:0] {
		ST_IDLE = 5'h01,
		ST_ROWS = 5'h02,
		ST_COLS = 5'h04,
		ST_EVAL = 5'h08,
		ST_WAIT = 5'h10
	} kpsc_state_t;

	typedef struct packed {
		kpsc_state_t st;
		logic [2:0] col;
		logic ph;
		logic [4:0] key;
		logic [15:0] waitCnt;
		logic [9:0] keyPins;
		logic [15:0] scanWait;
		logic evIrq;
		logic ovf;
		logic ovfIrqEn;
		logic [4:0] count;
		logic [15:0][7:0] fifo;
		logic [29:0] snap;
		logic [29:0] prevScan;
		logic [29:0] stable;
		logic [4:0] gndRow;
		logic [9:0] filt;
		logic [9:0][10:0] debCnt;
		logic [9:0] level;
		logic [9:0] irqEn;
		logic [9:0] irqSt;
		logic [9:0] pol;
		logic [9:0] evEn;
		logic [9:0] pend;
		logic [9:0] outEn;
		logic [9:0] outData;
		logic [15:0] rdata;
	} kpsc_regs_t;
endpackage
`default_nettype wire

// ==== rtl/kpsc_top.sv ====
// Keypad matrix scanner, input change detector and event FIFO.
// Assumes pin inputs synchronous to sys_clk and external resolution of
// each pin from pinOut and pinOeN; rows rely on the pull-up when released.
//
// Function
// - Five rows, five columns; unused pins stay free
// - Idle: rows pulled up, columns low, watch rows
// - Any configured row low starts a scan
// - Columns high, then each low, sample rows
// - Every configured row/column pair tested each scan
// - Press accepted after two scans across wait
// - Scan and wait repeat while keys held
// - Release accepted after two released scans
// - Idle again when nothing remains pressed
// - Key identifier row-major from one, five per row
// - Press: interrupt, count up, entry flag one
// - Release: count up, entry flag zero
// - Both press and release raise event interrupt
// - Grounded row reports extension identifier from 31
// - Grounded row hides its other keys
// - Input pin level readable by software
// - Per-input enable, sticky status, edge polarity
// - Summary interrupt when any input status set
// - Recording inputs push events, no summary interrupt
// - Input scanner updates once per transition, no wait
// - Inputs debounced about fifty microseconds
// - Each pin usable as general output
// - Entry: identifier bits six-zero, flag bit seven
// - Pushes held off during host FIFO access
// - More than sixteen events sets overflow, interrupt
`timescale 1ns/1ps
`default_nettype none

module kpsc_top
	import kpsc_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic [3:0] regAddr,
	input wire logic [15:0] regWrData,
	input wire logic regWr,
	input wire logic regRd,
	output logic [15:0] regRdData,
	input wire logic [9:0] pinIn,
	output logic [9:0] pinOut,
	output logic [9:0] pinOeN,
	output logic [4:0] rowPullUp,
	output logic eventIrq,
	output logic inputChangeIrq,
	output logic overflowIrq,
	output logic [4:0] eventCount
);

	kpsc_regs_t r_reg;
	kpsc_regs_t r_next;

	logic holdOff;
	logic [4:0] rowLow;
	logic push;
	logic [7:0] pushData;
	logic keyPush;
	logic [9:0] change;
	logic [9:0] gpiMask;
	logic edgeHit;
	logic pendFound;
	logic [4:0] colLow;

	////////////////////////////////////////////////////////////////////////
	// Pin drive. Pins 0-4 are rows, 5-9 columns.
	// A keypad pin ignores the output enable register: rows float onto their
	// pull-ups and columns are always driven, so a stray write cannot fight a key.

	always_comb begin
		colLow = 5'h00;
		for (int c = 0; c < NUM_COLS; c++) begin
			case (r_reg.st)
				ST_ROWS: colLow[c] = 1'b0;
				ST_COLS: colLow[c] = (r_reg.col == 3'(c));
				default: colLow[c] = 1'b1;
			endcase
		end
	end

	always_comb begin
		for (int p = 0; p < NUM_PINS; p++) begin
			pinOut[p] = r_reg.outData[p];
			pinOeN[p] = ~r_reg.outEn[p];
		end
		for (int rr = 0; rr < NUM_ROWS; rr++) begin
			rowPullUp[rr] = r_reg.keyPins[rr];
			if (r_reg.keyPins[rr]) begin
				pinOeN[rr] = 1'b1;
			end
		end
		for (int c = 0; c < NUM_COLS; c++) begin
			if (r_reg.keyPins[NUM_ROWS + c]) begin
				pinOut[NUM_ROWS + c] = ~colLow[c];
				pinOeN[NUM_ROWS + c] = 1'b0;
			end
		end
	end

	assign regRdData = r_reg.rdata;
	assign eventIrq = r_reg.evIrq;
	assign inputChangeIrq = |r_reg.irqSt;
	assign overflowIrq = r_reg.ovf & r_reg.ovfIrqEn;
	assign eventCount = r_reg.count;

	////////////////////////////////////////////////////////////////////////
	// Next-state logic.

	always_comb begin
		r_next = r_reg;
		push = 1'b0;
		pushData = 8'h00;
		keyPush = 1'b0;
		edgeHit = 1'b0;
		pendFound = 1'b0;
		// A pop shifts every entry, so a push in the same cycle could land in
		// the wrong slot; the source simply waits one cycle instead.
		holdOff = regRd && (regAddr == REG_FIFO_POP);
		rowLow = ~pinIn[4:0] & r_reg.keyPins[4:0];
		gpiMask = ~r_reg.keyPins & ~r_reg.outEn;
		change = (r_reg.filt ^ r_reg.level) & gpiMask;

		// Register writes come first so that hardware sets below win.
		// Unmapped indices fall through the default branches: writes are
		// dropped and reads return zero, so probing the map is harmless.
		if (regWr) begin
			case (regAddr)
				REG_KEY_PINS: r_next.keyPins = regWrData[9:0];
				REG_SCAN_WAIT: r_next.scanWait = regWrData;
				REG_STATUS: begin
					if (regWrData[STATUS_EVENT_BIT]) r_next.evIrq = 1'b0;
					if (regWrData[STATUS_OVF_BIT]) r_next.ovf = 1'b0;
				end
				REG_CTRL: r_next.ovfIrqEn = regWrData[CTRL_OVF_IRQ_EN_BIT];
				REG_INPUT_IRQ_EN: r_next.irqEn = regWrData[9:0];
				REG_INPUT_IRQ_STATUS: r_next.irqSt = r_reg.irqSt & ~regWrData[9:0];
				REG_INPUT_POLARITY: r_next.pol = regWrData[9:0];
				REG_INPUT_EVENT_EN: r_next.evEn = regWrData[9:0];
				REG_OUTPUT_EN: r_next.outEn = regWrData[9:0];
				REG_OUTPUT_DATA: r_next.outData = regWrData[9:0];
				default: ;
			endcase
		end

		// Register reads, data valid the following cycle.
		if (regRd) begin
			case (regAddr)
				REG_KEY_PINS: r_next.rdata = {6'h00, r_reg.keyPins};
				REG_SCAN_WAIT: r_next.rdata = r_reg.scanWait;
				REG_STATUS: r_next.rdata = {13'h0000, r_reg.ovf, |r_reg.irqSt, r_reg.evIrq};
				REG_CTRL: r_next.rdata = {15'h0000, r_reg.ovfIrqEn};
				REG_EVENT_COUNT: r_next.rdata = {11'h000, r_reg.count};
				REG_FIFO_POP: begin
					r_next.rdata = {8'h00, (r_reg.count != 5'h00) ? r_reg.fifo[0] : 8'h00};
					if (r_reg.count != 5'h00) begin
						for (int i = 0; i < FIFO_DEPTH - 1; i++) begin
							r_next.fifo[i] = r_reg.fifo[i + 1];
						end
						r_next.fifo[FIFO_DEPTH - 1] = 8'h00;
						r_next.count = r_reg.count - 5'h01;
					end
				end
				REG_INPUT_LEVEL: r_next.rdata = {6'h00, r_reg.level};
				REG_INPUT_IRQ_EN: r_next.rdata = {6'h00, r_reg.irqEn};
				REG_INPUT_IRQ_STATUS: r_next.rdata = {6'h00, r_reg.irqSt};
				REG_INPUT_POLARITY: r_next.rdata = {6'h00, r_reg.pol};
				REG_INPUT_EVENT_EN: r_next.rdata = {6'h00, r_reg.evEn};
				REG_OUTPUT_EN: r_next.rdata = {6'h00, r_reg.outEn};
				REG_OUTPUT_DATA: r_next.rdata = {6'h00, r_reg.outData};
				default: r_next.rdata = 16'h0000;
			endcase
		end

		// Input debounce filter.
		// The counter restarts whenever the pin agrees with the filtered value,
		// so only a level held for the whole window gets through; a pulse
		// shorter than the window is dropped entirely.
		for (int p = 0; p < NUM_PINS; p++) begin
			if (pinIn[p] != r_reg.filt[p]) begin
				if (r_reg.debCnt[p] >= DEBOUNCE_CYC - 11'h001) begin
					r_next.filt[p] = pinIn[p];
					r_next.debCnt[p] = 11'h000;
				end else begin
					r_next.debCnt[p] = r_reg.debCnt[p] + 11'h001;
				end
			end else begin
				r_next.debCnt[p] = 11'h000;
			end
		end

		// Input scanner: one update of all inputs per transition.
		// Masked pins (keypad or driven outputs) never update their level, so
		// their edges cannot raise status or fill the FIFO.
		if (|change) begin
			for (int p = 0; p < NUM_PINS; p++) begin
				if (change[p]) begin
					r_next.level[p] = r_reg.filt[p];
					edgeHit = (r_reg.filt[p] == r_reg.pol[p]);
					if (r_reg.evEn[p]) begin
						r_next.pend[p] = 1'b1;
					end else if (r_reg.irqEn[p] && edgeHit) begin
						r_next.irqSt[p] = 1'b1;
					end
				end
			end
		end

		// Key scanner.
		// Each drive pattern lasts two cycles: the first lets the row lines
		// settle through the pull-ups, the second samples them. Slow edges on
		// long keypad traces are the reason for the extra cycle.
		// The 30 evaluate cycles handle one key each, so a single push port
		// into the FIFO is enough and no arbitration between keys is needed.
		case (r_reg.st)
			ST_IDLE: begin
				if (|rowLow) begin
					r_next.st = ST_ROWS;
					r_next.ph = 1'b0;
				end
			end
			ST_ROWS: begin
				// All columns high: a row still low is tied to ground.
				r_next.ph = ~r_reg.ph;
				if (r_reg.ph) begin
					r_next.gndRow = rowLow;
					r_next.snap[29:25] = rowLow;
					r_next.col = 3'h0;
					r_next.st = ST_COLS;
				end
			end
			ST_COLS: begin
				r_next.ph = ~r_reg.ph;
				if (r_reg.ph) begin
					for (int c = 0; c < NUM_COLS; c++) begin
						for (int rr = 0; rr < NUM_ROWS; rr++) begin
							if (r_reg.col == 3'(c)) begin
								r_next.snap[rr * NUM_COLS + c] = rowLow[rr] & r_reg.keyPins[NUM_ROWS + c]
									& ~r_reg.gndRow[rr];
							end
						end
					end
					r_next.col = r_reg.col + 3'h1;
					if (r_reg.col == 3'(NUM_COLS - 1)) begin
						r_next.st = ST_EVAL;
						r_next.key = 5'h00;
					end
				end
			end
			ST_EVAL: begin
				if ((r_reg.snap[r_reg.key] == r_reg.prevScan[r_reg.key])
					&& (r_reg.snap[r_reg.key] != r_reg.stable[r_reg.key])) begin
					keyPush = 1'b1;
				end
				// A push refused by a FIFO read keeps the same key index, so the
				// comparison is simply repeated next cycle.
				if (!(keyPush && holdOff)) begin
					if (keyPush) begin
						push = 1'b1;
						r_next.stable[r_reg.key] = r_reg.snap[r_reg.key];
						pushData[ENTRY_FLAG_BIT] = r_reg.snap[r_reg.key];
						pushData[6:0] = (r_reg.key < 5'h19) ? 7'({2'b00, r_reg.key} + 7'h01)
							: 7'({2'b00, r_reg.key} - 7'h19 + EXT_KEY_BASE);
					end
					r_next.key = r_reg.key + 5'h01;
					if (r_reg.key == 5'(NUM_KEYS - 1)) begin
						r_next.prevScan = r_reg.snap;
						r_next.waitCnt = 16'h0000;
						if ((|r_next.stable) || (|r_reg.snap)) begin
							r_next.st = ST_WAIT;
						end else begin
							r_next.st = ST_IDLE;
						end
					end
				end
			end
			ST_WAIT: begin
				// A setting of zero still costs one cycle here, which keeps the
				// minimum gap between scans at one clock.
				r_next.waitCnt = r_reg.waitCnt + 16'h0001;
				if (r_next.waitCnt >= r_reg.scanWait) begin
					r_next.st = ST_ROWS;
					r_next.ph = 1'b0;
				end
			end
			default: r_next.st = ST_IDLE;
		endcase

		// Recorded input events drain one per cycle when keys are quiet.
		// The lowest numbered pin wins when several are pending; the rest
		// follow on later cycles.
		if (!keyPush && !holdOff) begin
			for (int p = NUM_PINS - 1; p >= 0; p--) begin
				if (r_reg.pend[p]) begin
					pendFound = 1'b1;
					pushData = {r_reg.level[p], 7'(INPUT_ID_BASE + 7'(p))};
				end
			end
			if (pendFound) begin
				push = 1'b1;
				for (int p = 0; p < NUM_PINS; p++) begin
					// A new edge on the pin being drained keeps its mark, so it
					// is recorded on a later cycle instead of being lost.
					if (r_reg.pend[p] && (pushData[6:0] == 7'(INPUT_ID_BASE + 7'(p)))
						&& !(change[p] && r_reg.evEn[p])) begin
						r_next.pend[p] = 1'b0;
					end
				end
			end
		end

		// FIFO write.
		// A push into a full FIFO is dropped rather than overwriting the oldest
		// entry, so software always reads the earliest events first.
		if (push) begin
			r_next.evIrq = 1'b1;
			if (r_reg.count == FIFO_FULL) begin
				r_next.ovf = 1'b1;
			end else begin
				r_next.fifo[r_reg.count[3:0]] = pushData;
				r_next.count = r_reg.count + 5'h01;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// State register.

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			r_reg <= '0;
			r_reg.st <= ST_IDLE;
			// Besides the state (ST_IDLE), the scan wait is the only field with a non-zero default.
			r_reg.scanWait <= SCAN_WAIT_RESET;
		end else begin
			r_reg <= r_next;
		end
	end

endmodule

`default_nettype wire

// ==== sim/kpsc_props.sv ====
// Port checker for the keypad scan and input event block.
// Bound to kpsc_top; sees the register port, row pull-ups and flags.
`timescale 1ns/1ps
`default_nettype none
module kpsc_props
	import kpsc_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic [3:0] regAddr,
	input wire logic [15:0] regWrData,
	input wire logic regWr,
	input wire logic regRd,
	input wire logic [15:0] regRdData,
	input wire logic [4:0] rowPullUp,
	input wire logic eventIrq,
	input wire logic inputChangeIrq,
	input wire logic overflowIrq,
	input wire logic [4:0] eventCount
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rstn);
	////////////////////////////////////////////////////////////////
	sequence s_pop;
		regRd && regAddr == REG_FIFO_POP;
	endsequence
	a_count_bound: assert property (eventCount <= FIFO_FULL) else $error("count above depth");
	a_count_step: assert property (
		eventCount == $past(eventCount) || eventCount == $past(eventCount) + 5'h01
		|| eventCount == $past(eventCount) - 5'h01) else $error("count jumped");
	a_pop_holds_push: assert property (
		s_pop ##0 eventCount != 5'h00 |=> eventCount == $past(eventCount) - 5'h01) else $error("pop not exact");
	a_pop_empty: assert property (
		s_pop ##0 eventCount == 5'h00 |=> regRdData == 16'h0000) else $error("empty pop");
	a_push_irq: assert property (eventCount > $past(eventCount) |-> ##[0:1] eventIrq) else $error("no irq");
	a_summary_irq: assert property (regRd && regAddr == REG_INPUT_IRQ_STATUS |=>
		(|regRdData[9:0]) == $past(inputChangeIrq)) else $error("summary mismatch");
	a_pullup_cfg: assert property (
		regWr && regAddr == REG_KEY_PINS |=> rowPullUp == $past(regWrData[4:0])) else $error("pull-up wrong");
	a_ovf_full: assert property (
		$rose(overflowIrq) && !$past(regWr) |-> eventCount == FIFO_FULL) else $error("overflow early");
endmodule
bind kpsc_top kpsc_props u_props(.sys_clk(sys_clk), .rstn(rstn), .regAddr(regAddr), .regWrData(regWrData),
	.regWr(regWr), .regRd(regRd), .regRdData(regRdData), .rowPullUp(rowPullUp), .eventIrq(eventIrq),
	.inputChangeIrq(inputChangeIrq), .overflowIrq(overflowIrq), .eventCount(eventCount));
`default_nettype wire

// ==== sim/kpsc_keypad_model.sv ====
// Switch matrix with grounding row keys, plus free input levels.
// A key only pulls its row low while its column pin reads low.
`timescale 1ns/1ps
`default_nettype none
module kpsc_keypad_model (
	input wire logic [9:0] pinOut,
	input wire logic [9:0] pinOeN,
	input wire logic [4:0] rowPullUp,
	input wire logic [24:0] keys,
	input wire logic [4:0] gndRow,
	input wire logic [9:0] general_input_pin,
	output logic [9:0] pinIn
);
	always_comb begin
		for (int c = 0; c < 5; c++) begin
			pinIn[5 + c] = pinOeN[5 + c] ? general_input_pin[5 + c] : pinOut[5 + c];
		end
		for (int r = 0; r < 5; r++) begin
			pinIn[r] = pinOeN[r] ? (rowPullUp[r] | general_input_pin[r]) : pinOut[r];
			if (gndRow[r]) begin
				pinIn[r] = 1'b0;
			end
			for (int c = 0; c < 5; c++) begin
				if (keys[r * 5 + c] && !pinIn[5 + c]) begin
					pinIn[r] = 1'b0;
				end
			end
		end
	end
endmodule
`default_nettype wire

// ==== sim/kpsc_top_tb.sv ====
// Self-checking bench: register tasks plus a keypad model on the pins.
// Reset is held low for three cycles; scan wait is shortened to 20.
`timescale 1ns/1ps
`default_nettype none
module kpsc_top_tb;
	import kpsc_pkg::*;
	logic sysClk = 1'b0;
	logic rstn = 1'b0;
	logic [3:0] regAddr = 4'h0;
	logic [15:0] regWrData = 16'h0000;
	logic regWr = 1'b0;
	logic regRd = 1'b0;
	logic [15:0] regRdData;
	logic [9:0] pinIn, pinOut, pinOeN, general_input_pin = 10'h000;
	logic [4:0] rowPullUp, eventCount, gndRow = 5'h00;
	logic [24:0] keys = 25'h0000000;
	logic eventIrq, inputChangeIrq, overflowIrq;
	int mismatches = 0;
	int samples_checked = 0;
	int cyc = 0;
	always #20 sysClk = ~sysClk;
	kpsc_top dut(.sys_clk(sysClk), .rstn(rstn), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
		.regRd(regRd), .regRdData(regRdData), .pinIn(pinIn), .pinOut(pinOut), .pinOeN(pinOeN),
		.rowPullUp(rowPullUp), .eventIrq(eventIrq), .inputChangeIrq(inputChangeIrq),
		.overflowIrq(overflowIrq), .eventCount(eventCount));
	kpsc_keypad_model partner(.pinOut(pinOut), .pinOeN(pinOeN), .rowPullUp(rowPullUp), .keys(keys),
		.gndRow(gndRow), .general_input_pin(general_input_pin), .pinIn(pinIn));
	////////////////////////////////////////////////////////////////
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge sysClk);
		regWr <= 1'b1;
		regAddr <= a;
		regWrData <= d;
		@(posedge sysClk);
		regWr <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [15:0] exp);
		@(posedge sysClk);
		regRd <= 1'b1;
		regAddr <= a;
		@(posedge sysClk);
		regRd <= 1'b0;
		#1 chk(regRdData, exp);
	endtask
	// Polls under a bound so a lost event cannot hang the run.
	task automatic waitCount(input logic [4:0] n);
		for (int i = 0; i < 1000 && eventCount !== n; i++) begin
			@(posedge sysClk);
			#1;
		end
		chk(16'(eventCount), 16'(n));
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	always @(posedge sysClk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			mismatches++;
			tally_and_finish();
		end
	end
	////////////////////////////////////////////////////////////////
	initial begin
		repeat (3) @(posedge sysClk);
		rstn <= 1'b1;
		rd(REG_SCAN_WAIT, SCAN_WAIT_RESET);
		rd(REG_FIFO_POP, 16'h0000);
		wr(REG_SCAN_WAIT, 16'h0014);
		wr(REG_KEY_PINS, 16'h0186);
		wr(REG_OUTPUT_EN, 16'h0012);
		wr(REG_OUTPUT_DATA, 16'h0010);
		@(posedge sysClk);
		#1 chk(16'(rowPullUp), 16'h0006);
		chk(16'(pinOeN), 16'h026F);
		chk(16'(pinOut), 16'h0010);
		rd(REG_KEY_PINS, 16'h0186);
		$display("test config done");
		keys[7] <= 1'b1;
		repeat (10) @(posedge sysClk);
		keys[7] <= 1'b0;
		repeat (300) @(posedge sysClk);
		#1 chk(16'(eventCount), 16'h0000);
		keys[7] <= 1'b1;
		waitCount(5'h01);
		chk(16'(eventIrq), 16'h0001);
		rd(REG_FIFO_POP, 16'h0088);
		wr(REG_STATUS, 16'h0001);
		@(posedge sysClk);
		#1 chk(16'(eventIrq), 16'h0000);
		keys[7] <= 1'b0;
		waitCount(5'h01);
		chk(16'(eventIrq), 16'h0001);
		rd(REG_FIFO_POP, 16'h0008);
		$display("test key done");
		gndRow[1] <= 1'b1;
		keys[7] <= 1'b1;
		waitCount(5'h01);
		rd(REG_FIFO_POP, 16'h00A0);
		repeat (200) @(posedge sysClk);
		#1 chk(16'(eventCount), 16'h0000);
		gndRow[1] <= 1'b0;
		keys[7] <= 1'b0;
		waitCount(5'h01);
		rd(REG_FIFO_POP, 16'h0020);
		$display("test ground done");
		wr(REG_INPUT_POLARITY, 16'h0201);
		wr(REG_INPUT_IRQ_EN, 16'h0201);
		wr(REG_INPUT_EVENT_EN, 16'h0001);
		general_input_pin[9] <= 1'b1;
		general_input_pin[0] <= 1'b1;
		repeat (1300) @(posedge sysClk);
		rd(REG_INPUT_LEVEL, 16'h0201);
		rd(REG_INPUT_IRQ_STATUS, 16'h0200);
		chk(16'(inputChangeIrq), 16'h0001);
		rd(REG_FIFO_POP, 16'h00A5);
		wr(REG_INPUT_IRQ_STATUS, 16'h0200);
		@(posedge sysClk);
		#1 chk(16'(inputChangeIrq), 16'h0000);
		general_input_pin <= 10'h000;
		repeat (1300) @(posedge sysClk);
		rd(REG_INPUT_IRQ_STATUS, 16'h0000);
		rd(REG_INPUT_LEVEL, 16'h0000);
		rd(REG_FIFO_POP, 16'h0025);
		$display("test input done");
		wr(REG_CTRL, 16'h0001);
		for (int i = 0; i < 8; i++) begin
			keys[7] <= 1'b1;
			waitCount(5'(2 * i + 1));
			keys[7] <= 1'b0;
			waitCount(5'(2 * i + 2));
		end
		keys[7] <= 1'b1;
		repeat (400) @(posedge sysClk);
		#1 chk(16'(eventCount), 16'h0010);
		chk(16'(overflowIrq), 16'h0001);
		rd(REG_STATUS, 16'h0005);
		rd(REG_FIFO_POP, 16'h0088);
		rd(REG_EVENT_COUNT, 16'h000F);
		$display("test overflow done");
		tally_and_finish();
	end
endmodule
`default_nettype wire
